/* mct_pkg.sv */
// Purpose: Shared constants for the match/capture timer counter
// Assumes: APB register map, 32-bit words, byte addresses
// Notes:   Offsets are byte addresses of aligned words
package mct_pkg;
  // Register byte offsets
  localparam logic [11:0] MCT_CTRL_OFS  = 12'h000; // Enable, reset, counter mode
  localparam logic [11:0] MCT_COUNT_OFS = 12'h004; // Counter value
  localparam logic [11:0] MCT_PRE_OFS   = 12'h008; // Prescale limit
  localparam logic [11:0] MCT_PCNT_OFS  = 12'h00C; // Prescale count
  localparam logic [11:0] MCT_MCTL_OFS  = 12'h010; // Match control
  localparam logic [11:0] MCT_CCTL_OFS  = 12'h014; // Capture control
  localparam logic [11:0] MCT_EMC_OFS   = 12'h018; // Match output control/state
  localparam logic [11:0] MCT_PWM_OFS   = 12'h01C; // PWM enables, DMA selects
  localparam logic [11:0] MCT_STAT_OFS  = 12'h020; // Sticky event status, W1C
  localparam logic [11:0] MCT_MASK_OFS  = 12'h024; // Interrupt mask
  localparam logic [11:0] MCT_MAT0_OFS  = 12'h030; // Match shadows, 4 words
  localparam logic [11:0] MCT_CAP0_OFS  = 12'h040; // Captures, 4 words
  // Control register fields
  localparam int MCT_CTRL_EN   = 0;
  localparam int MCT_CTRL_RST  = 1;
  localparam int MCT_CTRL_CNTM = 2; // 0 timer, 1 counter
  localparam int MCT_CTRL_EDGE = 3; // 2 bits: 1 rise, 2 fall, 3 both
  localparam int MCT_CTRL_CSEL = 5; // 2 bits: external clock input select
  // Match control: per match 3 bits {stop, reset, int}
  localparam int MCT_MCTL_W = 3;
  // Capture control: per capture 4 bits {clear, int, fall, rise}
  localparam int MCT_CCTL_W = 4;
  // Match output actions
  localparam logic [1:0] MCT_ACT_NONE = 2'h0;
  localparam logic [1:0] MCT_ACT_LOW  = 2'h1;
  localparam logic [1:0] MCT_ACT_HIGH = 2'h2;
  localparam logic [1:0] MCT_ACT_TOG  = 2'h3;
  localparam int MCT_NMAT = 4;
  localparam int MCT_NCAP = 4;
endpackage

/* mct_edge_sync.sv */
// Purpose: Two-flop synchroniser with edge detection for one pin
// Assumes: Pin is asynchronous to pclk
// Notes:   First flop feeds only the second flop
`timescale 1ns/1ns
`default_nettype none
module mct_edge_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;

  // Next values
  always_comb begin
    s1_d = pin;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // Synchroniser and edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  // Edges of the synchronised level
  assign level = s2_q;
  assign rise  = s2_q & ~s3_q;
  assign fall  = ~s2_q & s3_q;
endmodule
`default_nettype wire

/* mct_timer.sv */
// Purpose: 32-bit match/capture timer counter with APB registers
// Assumes: Single pclk domain; pins synchronised internally
// Notes:   Shadowed matches load when the counter restarts
//
// What this block does
// R1: The counter steps once each time the 32-bit prescaler passes its programmed limit.
// R2: Timer mode counts pclk cycles and counter mode counts chosen edges of an external clock.
// R3: Four 32-bit match registers compare the count and may raise an interrupt while counting goes on.
// R4: A match can be set to halt the counter and prescaler, optionally with an interrupt.
// R5: A match can be set to return the counter to zero and continue, optionally with an interrupt.
// R6: Match values go through shadow registers that load at counter restart so PWM never glitches.
// R7: Each match output can go low, go high, toggle or hold on its match.
// R8: A selected capture edge copies the count into that input's capture register, with optional interrupt.
// R9: Up to two match registers can be chosen to raise timed DMA requests.
// R10: A chosen capture event can clear both counter and prescaler for pulse width measurement.
// R11: Match outputs may run as single-edge PWM with a match register setting the period.
// R12: Capture and external clock pins are synchronised before edges are detected.
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ns
`default_nettype none
module mct_timer
  import mct_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  cap_in,
  output logic      [3:0]  match_out,
  output logic      [1:0]  dma_req,
  output logic             irq
);
  // Register state
  logic [31:0] ctrl_q, ctrl_d, tc_q, tc_d, pr_q, pr_d, pc_q, pc_d;
  logic [11:0] mctl_q, mctl_d;
  logic [15:0] cctl_q, cctl_d;
  logic [11:0] emc_q, emc_d;   // [3:0] output state, [11:4] actions
  logic [7:0]  pwmc_q, pwmc_d; // [3:0] PWM enable, [5:4] dma0 src, [7:6] dma1 src
  logic [7:0]  stat_q, stat_d, mask_q, mask_d; // [3:0] match, [7:4] capture
  logic [31:0] msh_q [MCT_NMAT];
  logic [31:0] msh_d [MCT_NMAT];
  logic [31:0] mact_q [MCT_NMAT];
  logic [31:0] mact_d [MCT_NMAT];
  logic [31:0] cap_q [MCT_NCAP];
  logic [31:0] cap_d [MCT_NCAP];
  logic [1:0]  dma_q, dma_d;
  logic [31:0] rdata_d;

  logic [3:0] cap_rise, cap_fall, cap_lvl;
  logic       wr, rd, tick, step, restart, halt, cap_clr;
  logic [3:0] mhit, cap_ev;
  logic [31:0] tc_next;

  // Pin synchronisers and edge detectors
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      mct_edge_sync u_sync (                                       // R12
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (cap_in[gi]),
        .level   (cap_lvl[gi]),
        .rise    (cap_rise[gi]),
        .fall    (cap_fall[gi])
      );
    end
  endgenerate

  // Bus strobes; zero wait states
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Selected external clock edge for counter mode
  function automatic logic ext_edge(input logic [1:0] sel, input logic [1:0] mode,
                                    input logic [3:0] r, input logic [3:0] f);
    ext_edge = (mode[0] & r[sel]) | (mode[1] & f[sel]);
  endfunction

  // Tick source, prescaler step, matches and captures
  always_comb begin
    if (ctrl_q[MCT_CTRL_CNTM])                                     // R2
      tick = ext_edge(ctrl_q[MCT_CTRL_CSEL+:2], ctrl_q[MCT_CTRL_EDGE+:2], cap_rise, cap_fall);
    else
      tick = 1'b1;
    tick = tick & ctrl_q[MCT_CTRL_EN] & ~ctrl_q[MCT_CTRL_RST];
    step = tick & (pc_q == pr_q);                                  // R1
    for (int i = 0; i < MCT_NMAT; i++)
      mhit[i] = step & (tc_q == mact_q[i]);                        // R3
    for (int i = 0; i < MCT_NCAP; i++)
      cap_ev[i] = (cctl_q[MCT_CCTL_W*i] & cap_rise[i]) |           // R8
                  (cctl_q[MCT_CCTL_W*i+1] & cap_fall[i]);
    restart = 1'b0;
    halt    = 1'b0;
    cap_clr = 1'b0;
    for (int i = 0; i < MCT_NMAT; i++) begin
      restart = restart | (mhit[i] & mctl_q[MCT_MCTL_W*i+1]);     // R5
      halt    = halt | (mhit[i] & mctl_q[MCT_MCTL_W*i+2]);        // R4
    end
    for (int i = 0; i < MCT_NCAP; i++)
      cap_clr = cap_clr | (cap_ev[i] & cctl_q[MCT_CCTL_W*i+3]);    // R10
    tc_next = restart ? 32'h0 : tc_q + 32'h1;
  end

  // Next state of all registers except prdata
  always_comb begin
    ctrl_d = ctrl_q;
    tc_d   = tc_q;
    pr_d   = pr_q;
    pc_d   = pc_q;
    mctl_d = mctl_q;
    cctl_d = cctl_q;
    emc_d  = emc_q;
    pwmc_d = pwmc_q;
    mask_d = mask_q;
    stat_d = stat_q;
    dma_d  = dma_q;
    for (int i = 0; i < MCT_NMAT; i++) begin
      msh_d[i]  = msh_q[i];
      mact_d[i] = mact_q[i];
    end
    for (int i = 0; i < MCT_NCAP; i++)
      cap_d[i] = cap_q[i];
    // Software writes; W1C on status
    if (wr) begin
      unique case (paddr)
        MCT_CTRL_OFS:  ctrl_d = {25'h0, pwdata[6:0]};
        MCT_COUNT_OFS: tc_d   = pwdata;
        MCT_PRE_OFS:   pr_d   = pwdata;
        MCT_PCNT_OFS:  pc_d   = pwdata;
        MCT_MCTL_OFS:  mctl_d = pwdata[11:0];
        MCT_CCTL_OFS:  cctl_d = pwdata[15:0];
        MCT_EMC_OFS:   emc_d  = pwdata[11:0];
        MCT_PWM_OFS:   pwmc_d = pwdata[7:0];
        MCT_STAT_OFS:  stat_d = stat_q & ~pwdata[7:0];
        MCT_MASK_OFS:  mask_d = pwdata[7:0];
        default: begin
          for (int i = 0; i < MCT_NMAT; i++)
            if (paddr == MCT_MAT0_OFS + 12'(4*i))
              msh_d[i] = pwdata;                                   // R6
        end
      endcase
    end
    // Counter reset bit holds count and prescaler at zero
    if (ctrl_q[MCT_CTRL_RST]) begin
      tc_d = 32'h0;
      pc_d = 32'h0;
    end else if (cap_clr) begin                                    // R10
      tc_d = 32'h0;
      pc_d = 32'h0;
    end else if (tick) begin
      pc_d = step ? 32'h0 : pc_q + 32'h1;                          // R1
      if (step && !halt)                                           // R4
        tc_d = tc_next;                                            // R5
    end
    // Stop on match clears the enable
    if (halt)
      ctrl_d[MCT_CTRL_EN] = 1'b0;                                  // R4
    // Shadow to active at restart or while stopped
    if (restart || cap_clr || ctrl_q[MCT_CTRL_RST] || !ctrl_q[MCT_CTRL_EN])
      for (int i = 0; i < MCT_NMAT; i++)
        mact_d[i] = msh_d[i];                                      // R6
    // Match output actions; PWM mode drives high at restart, low at match
    for (int i = 0; i < MCT_NMAT; i++) begin
      if (pwmc_q[i]) begin
        if (mhit[i])
          emc_d[i] = 1'b0;                                         // R11
        else if (restart)
          emc_d[i] = 1'b1;                                         // R11
      end else if (mhit[i]) begin
        unique case (emc_q[4+2*i +: 2])                            // R7
          MCT_ACT_NONE: emc_d[i] = emc_q[i];
          MCT_ACT_LOW:  emc_d[i] = 1'b0;
          MCT_ACT_HIGH: emc_d[i] = 1'b1;
          MCT_ACT_TOG:  emc_d[i] = ~emc_q[i];
        endcase
      end
    end
    // Captures
    for (int i = 0; i < MCT_NCAP; i++)
      if (cap_ev[i])
        cap_d[i] = tc_q;                                           // R8
    // Sticky status; set wins over clear
    for (int i = 0; i < MCT_NMAT; i++)
      if (mhit[i] && mctl_q[MCT_MCTL_W*i])
        stat_d[i] = 1'b1;                                          // R3
    for (int i = 0; i < MCT_NCAP; i++)
      if (cap_ev[i] && cctl_q[MCT_CCTL_W*i+2])
        stat_d[4+i] = 1'b1;                                        // R8
    // DMA request pulses from selected matches
    dma_d[0] = mhit[pwmc_q[5:4]];                                  // R9
    dma_d[1] = mhit[pwmc_q[7:6]];                                  // R9
  end

  // Read mux
  always_comb begin
    rdata_d = 32'h0;
    unique case (paddr)
      MCT_CTRL_OFS:  rdata_d = ctrl_q;
      MCT_COUNT_OFS: rdata_d = tc_q;
      MCT_PRE_OFS:   rdata_d = pr_q;
      MCT_PCNT_OFS:  rdata_d = pc_q;
      MCT_MCTL_OFS:  rdata_d = {20'h0, mctl_q};
      MCT_CCTL_OFS:  rdata_d = {16'h0, cctl_q};
      MCT_EMC_OFS:   rdata_d = {20'h0, emc_q};
      MCT_PWM_OFS:   rdata_d = {24'h0, pwmc_q};
      MCT_STAT_OFS:  rdata_d = {24'h0, stat_q};
      MCT_MASK_OFS:  rdata_d = {24'h0, mask_q};
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (paddr == MCT_MAT0_OFS + 12'(4*i))
            rdata_d = msh_q[i];
          if (paddr == MCT_CAP0_OFS + 12'(4*i))
            rdata_d = cap_q[i];
        end
      end
    endcase
  end

  // Register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 32'h0;
      tc_q   <= 32'h0;
      pr_q   <= 32'h0;
      pc_q   <= 32'h0;
      mctl_q <= 12'h0;
      cctl_q <= 16'h0;
      emc_q  <= 12'h0;
      pwmc_q <= 8'h0;
      stat_q <= 8'h0;
      mask_q <= 8'h0;
      dma_q  <= 2'h0;
      prdata <= 32'h0;
      for (int i = 0; i < 4; i++) begin
        msh_q[i]  <= 32'h0;
        mact_q[i] <= 32'h0;
        cap_q[i]  <= 32'h0;
      end
    end else begin
      ctrl_q <= ctrl_d;
      tc_q   <= tc_d;
      pr_q   <= pr_d;
      pc_q   <= pc_d;
      mctl_q <= mctl_d;
      cctl_q <= cctl_d;
      emc_q  <= emc_d;
      pwmc_q <= pwmc_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      dma_q  <= dma_d;
      if (rd)
        prdata <= rdata_d;
      for (int i = 0; i < 4; i++) begin
        msh_q[i]  <= msh_d[i];
        mact_q[i] <= mact_d[i];
        cap_q[i]  <= cap_d[i];
      end
    end
  end

  // Outputs
  assign match_out = emc_q[3:0];
  assign dma_req   = dma_q;
  assign irq       = |(stat_q & mask_q);

  // Assertions
  property p_pre_step;
    @(posedge pclk) disable iff (!presetn)
      (tick && pc_q != pr_q && !cap_clr) |=> (tc_q == $past(tc_q) && pc_q == $past(pc_q) + 32'h1);
  endproperty
  a_pre_step: assert property (p_pre_step) else $error("prescaler step wrong"); // R1

  property p_timer_tick;
    @(posedge pclk) disable iff (!presetn)
      (!ctrl_q[MCT_CTRL_CNTM] && ctrl_q[MCT_CTRL_EN] && !ctrl_q[MCT_CTRL_RST] && pr_q == 32'h0
        && !restart && !halt && !cap_clr && !wr) |=> tc_q == $past(tc_q) + 32'h1;
  endproperty
  a_timer_tick: assert property (p_timer_tick) else $error("timer mode lost tick"); // R2

  property p_match_int;
    @(posedge pclk) disable iff (!presetn)
      (mhit[0] && mctl_q[0]) |=> stat_q[0];
  endproperty
  a_match_int: assert property (p_match_int) else $error("match flag not set"); // R3

  property p_halt;
    @(posedge pclk) disable iff (!presetn)
      (halt && !wr) |=> (!ctrl_q[MCT_CTRL_EN] && tc_q == $past(tc_q)) ##1 (tc_q == $past(tc_q));
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not stop"); // R4

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
      (restart && !cap_clr && !wr) |=> tc_q == 32'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not zero"); // R5

  property p_shadow;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_q[MCT_CTRL_EN] && !ctrl_q[MCT_CTRL_RST] && !restart && !cap_clr && !halt)
        |=> mact_q[0] == $past(mact_q[0]);
  endproperty
  a_shadow: assert property (p_shadow) else $error("active match changed mid period"); // R6

  property p_toggle;
    @(posedge pclk) disable iff (!presetn)
      (mhit[0] && !pwmc_q[0] && emc_q[5:4] == MCT_ACT_TOG) |=> match_out[0] != $past(match_out[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle failed"); // R7

  property p_capture;
    @(posedge pclk) disable iff (!presetn)
      cap_ev[0] |=> cap_q[0] == $past(tc_q);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong"); // R8

  property p_dma;
    @(posedge pclk) disable iff (!presetn)
      mhit[pwmc_q[5:4]] |=> dma_req[0];
  endproperty
  a_dma: assert property (p_dma) else $error("dma request missing"); // R9

  property p_cap_clr;
    @(posedge pclk) disable iff (!presetn)
      (cap_clr && !ctrl_q[MCT_CTRL_RST]) |=> (tc_q == 32'h0 && pc_q == 32'h0);
  endproperty
  a_cap_clr: assert property (p_cap_clr) else $error("capture clear failed"); // R10

  property p_pwm;
    @(posedge pclk) disable iff (!presetn)
      (pwmc_q[1] && mhit[1]) |=> !match_out[1];
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm edge wrong"); // R11

  property p_sync;
    @(posedge pclk) disable iff (!presetn)
      cap_rise[3] |-> cap_lvl[3] ##1 !cap_rise[3];
  endproperty
  a_sync: assert property (p_sync) else $error("edge seen twice"); // R12
endmodule
`default_nettype wire

/* mct_pin_model.sv */
// Purpose: Model of the external pins facing the timer counter
// Assumes: Bench commands pin levels; pins are async to pclk
// Notes:   Pin edges land 1 ns after the command, off the clock edge
`timescale 1ns/1ns
`default_nettype none
module mct_pin_model (
  input  wire logic [3:0] pin_cmd,
  output wire logic [3:0] cap_in
);
  // Pins change out of step with pclk
  assign #1 cap_in = pin_cmd;
endmodule
`default_nettype wire

/* test_match_capture_timer_counter.sv */
// Purpose: Self-checking bench for the match/capture timer counter
// Assumes: APB with pready from the design; one pclk domain
// Notes:   Counts near pin edges are checked within a small range
`timescale 1ns/1ns
`default_nettype none
module test_match_capture_timer_counter;
  import mct_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  pin_cmd = 4'h0;
  logic [3:0]  cap_in;
  logic [3:0]  match_out;
  logic [1:0]  dma_req;
  logic        irq;
  int          miscompares = 0;
  int          num_checks = 0;
  logic [31:0] a;
  logic [31:0] b;
  int          i;

  // 250 MHz clock
  always #2 pclk = ~pclk;

  mct_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cap_in(cap_in), .match_out(match_out),
    .dma_req(dma_req), .irq(irq));
  mct_pin_model pins (.pin_cmd(pin_cmd), .cap_in(cap_in));

  // Verdict and end of run
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      chk(32'h1, 32'h0);
      conclude();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
    logic [31:0] d;
    apb(1'b1, ad, wd, d);
  endtask

  task automatic rd(input logic [11:0] ad, output logic [31:0] d);
    apb(1'b0, ad, 32'h0, d);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Reset state and unmapped place
  task automatic t_reset;
    rd(MCT_CTRL_OFS, a);
    chk(a, 32'h0);
    rd(MCT_STAT_OFS, a);
    chk(a, 32'h0);
    wr(12'h100, 32'hFFFFFFFF);
    rd(12'h100, a);
    chk(a, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
    chk({27'h0, irq, match_out}, 32'h0);
  endtask

  // Prescale 3: 40 cycles give ten steps
  task automatic t_prescale;
    wr(MCT_CTRL_OFS, 32'h2);
    wr(MCT_PRE_OFS, 32'h3);
    wr(MCT_CTRL_OFS, 32'h1);
    rd(MCT_COUNT_OFS, a);
    idle(37);
    rd(MCT_COUNT_OFS, b);
    chk(b - a, 32'hA);
  endtask

  // Stop on match 0 with interrupt, then clear
  task automatic t_stop;
    wr(MCT_CTRL_OFS, 32'h2);
    wr(MCT_MCTL_OFS, 32'h5);
    wr(MCT_MAT0_OFS, 32'h5);
    wr(MCT_PRE_OFS, 32'h1);
    wr(MCT_MASK_OFS, 32'h1);
    wr(MCT_CTRL_OFS, 32'h1);
    for (i = 0; i < 40; i++) begin
      rd(MCT_CTRL_OFS, a);
      if (a[0] === 1'b0) break;
    end
    chk(a[0], 1'b0);
    rd(MCT_COUNT_OFS, a);
    chk(a, 32'h5);
    chk(irq, 1'b1);
    wr(MCT_STAT_OFS, 32'h1);
    idle(1);
    chk(irq, 1'b0);
  endtask

  // Period 10 by reset, toggle, PWM, DMA, then shadow reload
  task automatic t_period;
    int tog;
    int dma;
    int dma1;
    int hi;
    logic m0;
    wr(MCT_CTRL_OFS, 32'h2);
    wr(MCT_PRE_OFS, 32'h0);
    wr(MCT_MCTL_OFS, 32'h3);
    wr(MCT_MAT0_OFS, 32'h9);
    wr(MCT_MAT0_OFS + 12'h4, 32'h3);
    wr(MCT_EMC_OFS, 32'h30);
    wr(MCT_PWM_OFS, 32'h42);
    wr(MCT_STAT_OFS, 32'hFF);
    wr(MCT_CTRL_OFS, 32'h1);
    tog = 0;
    dma = 0;
    dma1 = 0;
    hi = 0;
    m0 = match_out[0];
    repeat (100) begin
      @(posedge pclk);
      #1;
      tog += (match_out[0] !== m0);
      m0 = match_out[0];
      dma += (dma_req[0] === 1'b1);
      dma1 += (dma_req[1] === 1'b1);
      hi += (match_out[1] === 1'b1);
    end
    chk({31'h0, tog >= 9 && tog <= 11}, 32'h1);
    chk(dma, tog);
    chk(dma1, 32'd10);
    // High from restart through the count that matches: 4 of every 10
    chk({31'h0, hi >= 36 && hi <= 38}, 32'h1);
    rd(MCT_STAT_OFS, a);
    chk(a[0], 1'b1);
    wr(MCT_MAT0_OFS, 32'h4);
    idle(30);
    rd(MCT_COUNT_OFS, a);
    chk({31'h0, a <= 32'h4}, 32'h1);
  endtask

  // Clear on rise of pin 1, capture on fall of pin 2, capture once on pin 0
  task automatic t_capture;
    wr(MCT_CTRL_OFS, 32'h2);
    wr(MCT_MCTL_OFS, 32'h0);
    wr(MCT_CCTL_OFS, 32'h295);
    wr(MCT_MASK_OFS, 32'h10);
    wr(MCT_STAT_OFS, 32'hFF);
    wr(MCT_CTRL_OFS, 32'h1);
    pin_cmd <= 4'h7;
    idle(40);
    pin_cmd <= 4'h0;
    idle(10);
    rd(MCT_CAP0_OFS + 12'h8, a);
    chk({31'h0, a >= 32'd38 && a <= 32'd42}, 32'h1);
    rd(MCT_CAP0_OFS, a);
    chk(a, 32'h2);
    chk(irq, 1'b1);
    idle(10);
    rd(MCT_CAP0_OFS, b);
    chk(b, a);
  endtask

  // Counter mode on pin 3 rising edges
  task automatic t_count;
    wr(MCT_CTRL_OFS, 32'h2);
    wr(MCT_CTRL_OFS, 32'h6D);
    repeat (6) begin
      pin_cmd <= 4'h8;
      idle(8);
      pin_cmd <= 4'h0;
      idle(8);
    end
    rd(MCT_COUNT_OFS, a);
    chk(a, 32'h6);
  endtask

  // Main sequence
  initial begin
    idle(8);
    presetn <= 1'b1;
    idle(2);
    t_reset();
    t_prescale();
    t_stop();
    t_period();
    t_capture();
    t_count();
    conclude();
  end
endmodule
`default_nettype wire
